// ==== core/swlcs_pkg.sv ====
// Constants, register map and helpers of the switch link setup block.
package swlcs_pkg;

    localparam int LINK_COUNT = 8;
    localparam int DATA_W     = 32;
    localparam int IDX_W      = 8;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_SWITCH_CFG   = 8'h04;
    localparam logic [7:0] IDX_SPARE_A      = 8'h10;
    localparam logic [7:0] IDX_SPARE_B      = 8'h11;
    localparam logic [7:0] IDX_DEBUG_ORIGIN = 8'h1f;
    localparam logic [7:0] IDX_EXT_STATUS   = 8'h20;
    localparam logic [7:0] IDX_PROC_STATUS  = 8'h40;
    localparam logic [7:0] IDX_EXT_SETUP    = 8'h80;
    localparam logic [7:0] IDX_FIXED_FWD    = 8'ha0;

    // Field widths
    localparam int KIND_W = 2;
    localparam int DEST_W = 8;
    localparam int DIR_W  = 4;
    localparam int NET_W  = 2;
    localparam int GAP_W  = 11;
    localparam int CHAN_W = 5;
    localparam int SPARE_W = 2;
    localparam int DBG_W  = 5;

    // Field positions
    localparam int LOCK_BIT       = 31;
    localparam int KIND_LSB       = 24;
    localparam int DEST_LSB       = 16;
    localparam int DIR_LSB        = 8;
    localparam int NET_LSB        = 4;
    localparam int JUNK_BIT       = 2;
    localparam int DBUSY_BIT      = 1;
    localparam int SBUSY_BIT      = 0;
    localparam int EN_BIT         = 31;
    localparam int WIDE_BIT       = 30;
    localparam int RXERR_BIT      = 27;
    localparam int CRED_GIVEN_BIT = 26;
    localparam int CRED_HELD_BIT  = 25;
    localparam int CREDIT_REQUEST_TOKEN_BIT      = 24;
    localparam int RXRST_BIT      = 23;
    localparam int SYM_GAP_LSB    = 11;
    localparam int TOK_GAP_LSB    = 0;
    localparam int FWD_EN_BIT     = 31;
    localparam int FWD_PROC_BIT   = 8;
    localparam int FWD_CHAN_LSB   = 0;

    // Writable bits of each register
    localparam logic [31:0] WMASK_SWITCH_CFG = 32'h8000_0000;
    localparam logic [31:0] WMASK_SPARE      = 32'h0000_0003;
    localparam logic [31:0] WMASK_DEBUG      = 32'h0000_0013;
    localparam logic [31:0] WMASK_EXT_STATUS = 32'h0000_0f30;
    localparam logic [31:0] WMASK_PROC_STAT  = 32'h0000_0030;
    localparam logic [31:0] WMASK_EXT_SETUP  = 32'hc03f_ffff;
    localparam logic [31:0] WMASK_FIXED_FWD  = 32'h8000_011f;

    // Reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        PACE_WAIT_CREDIT = 3'b001,
        PACE_READY       = 3'b010,
        PACE_GAP         = 3'b100
    } swlcs_pace_state_type;

    // Byte-lane and field-mask merge of a register write
    function automatic logic [31:0] swlcs_merge(
        input logic [31:0] old_v,
        input logic [31:0] wdat,
        input logic [3:0]  sel,
        input logic [31:0] wmask
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
        return (old_v & ~m) | (wdat & m);
    endfunction : swlcs_merge

    // Fixed forwarding slot to link letter: C D A B G H E F
    function automatic logic [2:0] swlcs_fwd_link(input logic [2:0] slot);
        logic [2:0] l;
        l = 3'h0;
        case (slot)
            3'h0: l = 3'h2;
            3'h1: l = 3'h3;
            3'h2: l = 3'h0;
            3'h3: l = 3'h1;
            3'h4: l = 3'h6;
            3'h5: l = 3'h7;
            3'h6: l = 3'h4;
            default: l = 3'h5;
        endcase
        return l;
    endfunction : swlcs_fwd_link

endpackage : swlcs_pkg

// ==== core/swlcs_tx_pacer.sv ====
// Transmit pacing of one link: credit gate and idle gaps.
`timescale 1ns/1ps
module swlcs_tx_pacer
    import swlcs_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             enable_i,
    input  wire logic             credit_i,
    input  wire logic [GAP_W-1:0] sym_gap_i,
    input  wire logic [GAP_W-1:0] tok_gap_i,
    input  wire logic             valid_i,
    input  wire logic             last_i,
    output logic                  ready_o
);
    typedef struct packed {
        swlcs_pace_state_type state;
        logic [GAP_W:0]       cnt;
        logic                 ready;
    } swlcs_pace_type;

    swlcs_pace_type pace_reg;
    swlcs_pace_type pace_next;

    always_comb begin
        pace_next = pace_reg;
        if (!enable_i) begin
            pace_next.state = PACE_WAIT_CREDIT;
            pace_next.ready = 1'b0;
            pace_next.cnt   = '0;
        end else begin
            case (pace_reg.state)
                PACE_WAIT_CREDIT: begin
                    if (credit_i) begin
                        pace_next.state = PACE_READY;
                        pace_next.ready = 1'b1;
                    end
                end
                PACE_READY: begin
                    if (valid_i) begin
                        pace_next.cnt = last_i
                            ? {1'b0, tok_gap_i} + {{GAP_W{1'b0}}, 1'b1}
                            : {1'b0, sym_gap_i} + {{GAP_W{1'b0}}, 1'b1};
                        pace_next.state = PACE_GAP;
                        pace_next.ready = 1'b0;
                    end else if (!credit_i) begin
                        pace_next.state = PACE_WAIT_CREDIT;
                        pace_next.ready = 1'b0;
                    end
                end
                PACE_GAP: begin
                    pace_next.cnt = pace_reg.cnt - {{GAP_W{1'b0}}, 1'b1};
                    if (pace_reg.cnt == {{GAP_W{1'b0}}, 1'b1}) begin
                        pace_next.state = credit_i ? PACE_READY
                                                   : PACE_WAIT_CREDIT;
                        pace_next.ready = credit_i;
                    end
                end
                default: begin
                    pace_next.state = PACE_WAIT_CREDIT;
                    pace_next.ready = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pace_reg.state <= PACE_WAIT_CREDIT;
            pace_reg.cnt   <= '0;
            pace_reg.ready <= 1'b0;
        end else if (ce_i) begin
            pace_reg <= pace_next;
        end
    end

    assign ready_o = pace_reg.ready;

    a_credit_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ready_o) |-> $past(credit_i))
        else $error("ready raised without credit");
    a_gap_after_sym: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && ready_o && valid_i && enable_i |=> !ready_o)
        else $error("no idle cycle after a symbol");
endmodule : swlcs_tx_pacer

// ==== core/swlcs_link_setup.sv ====
// Link setup, status and fixed forwarding registers on Wishbone.
//
// Contract
// - Debug origin records core of last event
// - Status shows read-only source target kind
// - Status shows destination link while in use
// - Writable four-bit direction per external link
// - Writable two-bit network number per link
// - Junk packet flag, read-only
// - Destination and source busy flags, read-only
// - Processor links: same fields, no direction
// - Top setup bit enables or disables link
// - Width bit: two or five wires
// - Error flag on overflow or bad token
// - Flag: credit granted to remote end
// - Flag: credit held; transmit only with credit
// - Write one: clear credit, send credit request
// - Write one: restart receiver token framing
// - Idle clocks between symbols, minus one
// - Idle clocks between tokens, minus one
// - Fixed forwarding bypasses routing when enabled
// - Forwarding slots map to C D A B G H E F
// - Forwarding processor bit and channel end
// - Write lock refuses all register writes
`timescale 1ns/1ps
module swlcs_link_setup
    import swlcs_pkg::*;
#(
    parameter int LINKS  = LINK_COUNT,
    parameter int PLINKS = LINK_COUNT,
    parameter int ADDR_W = 10
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic                           ce_i,
    input  wire logic                           cyc_i,
    input  wire logic                           stb_i,
    input  wire logic                           we_i,
    input  wire logic [ADDR_W-1:0]              adr_i,
    input  wire logic [3:0]                     sel_i,
    input  wire logic [DATA_W-1:0]              dat_i,
    output logic      [DATA_W-1:0]              dat_o,
    output logic                                ack_o,
    input  wire logic                           dbg_event_i,
    input  wire logic [1:0]                     dbg_core_i,
    input  wire logic [LINKS-1:0][KIND_W-1:0]   ext_kind_i,
    input  wire logic [LINKS-1:0][DEST_W-1:0]   ext_dest_i,
    input  wire logic [LINKS-1:0]               ext_junk_i,
    input  wire logic [LINKS-1:0]               ext_dest_busy_i,
    input  wire logic [LINKS-1:0]               ext_src_busy_i,
    input  wire logic [LINKS-1:0]               ext_rx_error_i,
    input  wire logic [LINKS-1:0]               ext_credit_given_i,
    input  wire logic [LINKS-1:0]               ext_credit_held_i,
    input  wire logic [PLINKS-1:0][KIND_W-1:0]  proc_kind_i,
    input  wire logic [PLINKS-1:0][DEST_W-1:0]  proc_dest_i,
    input  wire logic [PLINKS-1:0]              proc_junk_i,
    input  wire logic [PLINKS-1:0]              proc_dest_busy_i,
    input  wire logic [PLINKS-1:0]              proc_src_busy_i,
    input  wire logic [LINKS-1:0]               tx_sym_valid_i,
    input  wire logic [LINKS-1:0]               tx_sym_last_i,
    output logic      [LINKS-1:0]               tx_sym_ready_o,
    output logic      [LINKS-1:0]               link_enable_o,
    output logic      [LINKS-1:0]               wide_mode_o,
    output logic      [LINKS-1:0][DIR_W-1:0]    direction_o,
    output logic      [LINKS-1:0][NET_W-1:0]    network_o,
    output logic      [PLINKS-1:0][NET_W-1:0]   proc_network_o,
    output logic      [LINKS-1:0][GAP_W-1:0]    sym_gap_o,
    output logic      [LINKS-1:0][GAP_W-1:0]    tok_gap_o,
    output logic      [LINKS-1:0]               credit_request_token_o,
    output logic      [LINKS-1:0]               rx_reset_o,
    output logic      [LINK_COUNT-1:0]          fwd_enable_o,
    output logic      [LINK_COUNT-1:0]          fwd_proc_o,
    output logic      [LINK_COUNT-1:0][CHAN_W-1:0] fwd_chanend_o
);
    if (LINKS < 1 || LINKS > LINK_COUNT) begin : g_chk_links
        $error("LINKS must be 1 to 8");
    end
    if (PLINKS < 1 || PLINKS > LINK_COUNT) begin : g_chk_plinks
        $error("PLINKS must be 1 to 8");
    end
    if (ADDR_W < IDX_W + 2) begin : g_chk_addr
        $error("ADDR_W too narrow for the map");
    end

    // All register state in one flop set
    typedef struct packed {
        logic                             ack;
        logic [DATA_W-1:0]                rdata;
        logic                             lock;
        logic [SPARE_W-1:0]               spare_a;
        logic [SPARE_W-1:0]               spare_b;
        logic [DBG_W-1:0]                 dbg;
        logic [LINKS-1:0][DIR_W-1:0]      dir;
        logic [LINKS-1:0][NET_W-1:0]      net;
        logic [PLINKS-1:0][NET_W-1:0]     pnet;
        logic [LINKS-1:0]                 en;
        logic [LINKS-1:0]                 wide;
        logic [LINKS-1:0][GAP_W-1:0]      sgap;
        logic [LINKS-1:0][GAP_W-1:0]      tgap;
        logic [LINKS-1:0]                 credit_request_token;
        logic [LINKS-1:0]                 rxrst;
        logic [LINK_COUNT-1:0]            fen;
        logic [LINK_COUNT-1:0]            fproc;
        logic [LINK_COUNT-1:0][CHAN_W-1:0] fchan;
    } swlcs_regs_type;

    swlcs_regs_type regs_reg;
    swlcs_regs_type regs_next;

    // Bus decode; a held request is taken every second cycle
    logic [IDX_W-1:0] idx;
    logic             req;
    logic             wr_go;

    assign idx   = adr_i[IDX_W+1:2];
    assign req   = cyc_i && stb_i && !regs_reg.ack;
    assign wr_go = req && we_i && !regs_reg.lock;

    // Index inside a block of n registers
    function automatic logic in_range(input logic [IDX_W-1:0] i,
                                      input logic [IDX_W-1:0] base,
                                      input int n);
        return (i >= base) && ({1'b0, i} < {1'b0, base} + (IDX_W+1)'(n));
    endfunction : in_range

    always_comb begin
        logic [2:0]        slot;
        logic [2:0]        lk;
        logic [31:0]       img;
        logic [31:0]       nv;
        slot = idx[2:0];
        lk   = swlcs_fwd_link(slot);
        img  = RST_ZERO;
        nv   = RST_ZERO;
        regs_next       = regs_reg;
        regs_next.ack   = req;
        regs_next.credit_request_token = '0;
        regs_next.rxrst = '0;
        if (idx == IDX_SWITCH_CFG) begin
            img = 32'(regs_reg.lock) << LOCK_BIT;
            nv  = swlcs_merge(img, dat_i, sel_i, WMASK_SWITCH_CFG);
            if (wr_go) begin
                regs_next.lock = nv[LOCK_BIT];
            end
        end else if (idx == IDX_SPARE_A) begin
            img = 32'(regs_reg.spare_a);
            nv  = swlcs_merge(img, dat_i, sel_i, WMASK_SPARE);
            if (wr_go) begin
                regs_next.spare_a = nv[SPARE_W-1:0];
            end
        end else if (idx == IDX_SPARE_B) begin
            img = 32'(regs_reg.spare_b);
            nv  = swlcs_merge(img, dat_i, sel_i, WMASK_SPARE);
            if (wr_go) begin
                regs_next.spare_b = nv[SPARE_W-1:0];
            end
        end else if (idx == IDX_DEBUG_ORIGIN) begin
            img = 32'(regs_reg.dbg);
            nv  = swlcs_merge(img, dat_i, sel_i, WMASK_DEBUG);
            if (wr_go) begin
                regs_next.dbg = nv[DBG_W-1:0];
            end
        end else if (in_range(idx, IDX_EXT_STATUS, LINKS)) begin
            img = (32'(ext_kind_i[slot]) << KIND_LSB)
                | (32'(ext_dest_i[slot]) << DEST_LSB)
                | (32'(regs_reg.dir[slot]) << DIR_LSB)
                | (32'(regs_reg.net[slot]) << NET_LSB)
                | (32'(ext_junk_i[slot]) << JUNK_BIT)
                | (32'(ext_dest_busy_i[slot]) << DBUSY_BIT)
                | (32'(ext_src_busy_i[slot]) << SBUSY_BIT);
            nv = swlcs_merge(img, dat_i, sel_i, WMASK_EXT_STATUS);
            if (wr_go) begin
                regs_next.dir[slot] = nv[DIR_LSB +: DIR_W];
                regs_next.net[slot] = nv[NET_LSB +: NET_W];
            end
        end else if (in_range(idx, IDX_PROC_STATUS, PLINKS)) begin
            img = (32'(proc_kind_i[slot]) << KIND_LSB)
                | (32'(proc_dest_i[slot]) << DEST_LSB)
                | (32'(regs_reg.pnet[slot]) << NET_LSB)
                | (32'(proc_junk_i[slot]) << JUNK_BIT)
                | (32'(proc_dest_busy_i[slot]) << DBUSY_BIT)
                | (32'(proc_src_busy_i[slot]) << SBUSY_BIT);
            nv = swlcs_merge(img, dat_i, sel_i, WMASK_PROC_STAT);
            if (wr_go) begin
                regs_next.pnet[slot] = nv[NET_LSB +: NET_W];
            end
        end else if (in_range(idx, IDX_EXT_SETUP, LINKS)) begin
            img = (32'(regs_reg.en[slot]) << EN_BIT)
                | (32'(regs_reg.wide[slot]) << WIDE_BIT)
                | (32'(ext_rx_error_i[slot]) << RXERR_BIT)
                | (32'(ext_credit_given_i[slot]) << CRED_GIVEN_BIT)
                | (32'(ext_credit_held_i[slot]) << CRED_HELD_BIT)
                | (32'(regs_reg.sgap[slot]) << SYM_GAP_LSB)
                | (32'(regs_reg.tgap[slot]) << TOK_GAP_LSB);
            nv = swlcs_merge(img, dat_i, sel_i, WMASK_EXT_SETUP);
            if (wr_go) begin
                regs_next.en[slot]   = nv[EN_BIT];
                regs_next.wide[slot] = nv[WIDE_BIT];
                regs_next.sgap[slot] = nv[SYM_GAP_LSB +: GAP_W];
                regs_next.tgap[slot] = nv[TOK_GAP_LSB +: GAP_W];
                regs_next.credit_request_token[slot] = sel_i[3] && dat_i[CREDIT_REQUEST_TOKEN_BIT];
                regs_next.rxrst[slot] = sel_i[2] && dat_i[RXRST_BIT];
            end
        end else if (in_range(idx, IDX_FIXED_FWD, LINK_COUNT)) begin
            img = (32'(regs_reg.fen[lk]) << FWD_EN_BIT)
                | (32'(regs_reg.fproc[lk]) << FWD_PROC_BIT)
                | (32'(regs_reg.fchan[lk]) << FWD_CHAN_LSB);
            nv = swlcs_merge(img, dat_i, sel_i, WMASK_FIXED_FWD);
            if (wr_go) begin
                regs_next.fen[lk]   = nv[FWD_EN_BIT];
                regs_next.fproc[lk] = nv[FWD_PROC_BIT];
                regs_next.fchan[lk] = nv[FWD_CHAN_LSB +: CHAN_W];
            end
        end
        // Unmapped indices answer with zero and store nothing
        regs_next.rdata = req ? img : regs_reg.rdata;
        // Debug event wins over a same-cycle software write
        if (dbg_event_i) begin
            regs_next.dbg[1:0] = dbg_core_i;
        end
    end

    // Reset wins; clock enable freezes all
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            regs_reg <= '0;
        end else if (ce_i) begin
            regs_reg <= regs_next;
        end
    end

    // One transmit pacer per external link
    for (genvar g = 0; g < LINKS; g++) begin : g_pacer
        swlcs_tx_pacer u_pacer (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .ce_i      (ce_i),
            .enable_i  (regs_reg.en[g]),
            .credit_i  (ext_credit_held_i[g]),
            .sym_gap_i (regs_reg.sgap[g]),
            .tok_gap_i (regs_reg.tgap[g]),
            .valid_i   (tx_sym_valid_i[g]),
            .last_i    (tx_sym_last_i[g]),
            .ready_o   (tx_sym_ready_o[g])
        );
    end

    // Every output straight from a flop
    assign dat_o          = regs_reg.rdata;
    assign ack_o          = regs_reg.ack;
    assign link_enable_o  = regs_reg.en;
    assign wide_mode_o    = regs_reg.wide;
    assign direction_o    = regs_reg.dir;
    assign network_o      = regs_reg.net;
    assign proc_network_o = regs_reg.pnet;
    assign sym_gap_o      = regs_reg.sgap;
    assign tok_gap_o      = regs_reg.tgap;
    assign credit_request_token_o        = regs_reg.credit_request_token;
    assign rx_reset_o     = regs_reg.rxrst;
    assign fwd_enable_o   = regs_reg.fen;
    assign fwd_proc_o     = regs_reg.fproc;
    assign fwd_chanend_o  = regs_reg.fchan;

    // Bus and register checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_lock_refuse: assert property (
        ce_i && regs_reg.lock && req && we_i
        |=> $stable(link_enable_o) && $stable(direction_o)
            && $stable(fwd_enable_o) && $stable(sym_gap_o))
        else $error("locked write changed a register");

    a_dbg_record: assert property (
        ce_i && dbg_event_i |=> regs_reg.dbg[1:0] == $past(dbg_core_i))
        else $error("debug origin not recorded");

    a_credit_request_token_cause: assert property (
        credit_request_token_o[0] |-> $past(wr_go && idx == IDX_EXT_SETUP
                             && sel_i[3] && dat_i[CREDIT_REQUEST_TOKEN_BIT]))
        else $error("credit request pulse without write");

    a_rx_restart: assert property (
        ce_i && wr_go && idx == IDX_EXT_SETUP && sel_i[2] && dat_i[RXRST_BIT]
        |=> rx_reset_o[0] ##1 (!ce_i || !rx_reset_o[0]))
        else $error("receiver restart pulse wrong");

    a_fwd_map: assert property (
        ce_i && wr_go && idx == IDX_FIXED_FWD && sel_i[3]
        |=> fwd_enable_o[2] == $past(dat_i[FWD_EN_BIT]))
        else $error("first forwarding slot not link C");

    a_dir_write: assert property (
        ce_i && wr_go && idx == IDX_EXT_STATUS && sel_i[1]
        |=> direction_o[0] == $past(dat_i[DIR_LSB +: DIR_W]))
        else $error("direction write lost");

    a_net_write: assert property (
        ce_i && wr_go && idx == IDX_EXT_STATUS && sel_i[0]
        |=> network_o[0] == $past(dat_i[NET_LSB +: NET_W]))
        else $error("network write lost");

    a_reset_zero: assert property (
        @(posedge clk_i) disable iff (1'b0)
        rst_i |=> wide_mode_o == '0 && link_enable_o == '0
                  && sym_gap_o == '0 && fwd_enable_o == '0)
        else $error("setup fields not zero after reset");

    a_junk_read: assert property (
        ce_i && req && !we_i && idx == IDX_EXT_STATUS
        |=> ack_o && dat_o[JUNK_BIT] == $past(ext_junk_i[0]))
        else $error("junk flag read wrong");

    a_ack_single: assert property (
        ce_i && ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");

    a_lock_sticky: assert property (
        regs_reg.lock |=> regs_reg.lock)
        else $error("write lock cleared");

    a_tgap_write: assert property (
        ce_i && wr_go && idx == IDX_EXT_SETUP && sel_i[1:0] == 2'h3
        |=> tok_gap_o[0] == $past(dat_i[TOK_GAP_LSB +: GAP_W]))
        else $error("token gap write lost");

    a_pnet_write: assert property (
        ce_i && wr_go && idx == IDX_PROC_STATUS && sel_i[0]
        |=> proc_network_o[0] == $past(dat_i[NET_LSB +: NET_W]))
        else $error("processor link network lost");

    // Main scenarios
    c_lock_set: cover property (wr_go && idx == IDX_SWITCH_CFG
                                && dat_i[LOCK_BIT] && sel_i[3]);

    c_dbg_event: cover property (ce_i && dbg_event_i && wr_go
                                 && idx == IDX_DEBUG_ORIGIN);

    c_credit_request_token: cover property (credit_request_token_o[0]);

    c_fwd_en: cover property (fwd_enable_o[5]);

    c_pace_ready: cover property (tx_sym_ready_o[0]);
endmodule : swlcs_link_setup

// ==== testbench/swlcs_far_end.sv ====
// Remote link end: grants credit a few cycles after enable or request.
`timescale 1ns/1ps
module swlcs_far_end
    import swlcs_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [LINK_COUNT-1:0] enable_i,
    input  wire logic [LINK_COUNT-1:0] credit_request_token_i,
    output logic      [LINK_COUNT-1:0] held_o,
    output logic      [LINK_COUNT-1:0] given_o
);
    logic [LINK_COUNT-1:0][2:0] wait_reg;
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < LINK_COUNT; i++) begin
            if (rst_i || !enable_i[i]) begin
                held_o[i] <= 1'b0;
                given_o[i] <= 1'b0;
                wait_reg[i] <= 3'h4;
            end else if (credit_request_token_i[i]) begin
                held_o[i] <= 1'b0;
                wait_reg[i] <= 3'h4;
            end else begin
                given_o[i] <= 1'b1;
                if (wait_reg[i] != 3'h0) wait_reg[i] <= wait_reg[i] - 3'h1;
                else held_o[i] <= 1'b1;
            end
        end
    end
endmodule : swlcs_far_end

// ==== testbench/swlcs_link_setup_tb.sv ====
// Bench for the link setup, status and forwarding registers.
`timescale 1ns/1ps
module swlcs_link_setup_tb
    import swlcs_pkg::*;
;
    logic clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o, dbg_event_i;
    logic [9:0] adr_i;
    logic [3:0] sel_i;
    logic [31:0] dat_i, dat_o, rd, e;
    logic [1:0] dbg_core_i;
    logic [7:0][1:0] ext_kind_i, proc_kind_i, network_o, proc_network_o;
    logic [7:0][7:0] ext_dest_i, proc_dest_i;
    logic [7:0] ext_junk_i, ext_dest_busy_i, ext_src_busy_i, ext_rx_error_i;
    logic [7:0] ext_credit_given_i, ext_credit_held_i, proc_junk_i, hel;
    logic [7:0] proc_dest_busy_i, proc_src_busy_i, tx_sym_valid_i, rxr;
    logic [7:0] tx_sym_last_i, tx_sym_ready_o, link_enable_o, wide_mode_o;
    logic [7:0] credit_request_token_o, rx_reset_o, fwd_enable_o, fwd_proc_o;
    logic [7:0][3:0] direction_o;
    logic [7:0][10:0] sym_gap_o, tok_gap_o;
    logic [7:0][4:0] fwd_chanend_o;
    int error_cnt = 0;
    int compares = 0;
    int let_t[8] = '{2, 3, 0, 1, 6, 7, 4, 5};
    swlcs_link_setup dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i,
        .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .dbg_event_i, .dbg_core_i,
        .ext_kind_i, .ext_dest_i, .ext_junk_i, .ext_dest_busy_i,
        .ext_src_busy_i, .ext_rx_error_i, .ext_credit_given_i,
        .ext_credit_held_i, .proc_kind_i, .proc_dest_i, .proc_junk_i,
        .proc_dest_busy_i, .proc_src_busy_i, .tx_sym_valid_i, .tx_sym_last_i,
        .tx_sym_ready_o, .link_enable_o, .wide_mode_o, .direction_o,
        .network_o, .proc_network_o, .sym_gap_o, .tok_gap_o, .credit_request_token_o,
        .rx_reset_o, .fwd_enable_o, .fwd_proc_o, .fwd_chanend_o);
    swlcs_far_end far (.clk_i, .rst_i, .enable_i(link_enable_o),
        .credit_request_token_i(credit_request_token_o), .held_o(ext_credit_held_i),
        .given_o(ext_credit_given_i));
    task automatic results;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [31:0] x, g);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] i, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, i, 2'b00, d};
        sel_i <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        {rd, hel, rxr} = {dat_o, credit_request_token_o, rx_reset_o};
        {cyc_i, stb_i} <= 2'b00;
        if (ack_o !== 1'b1) begin
            error_cnt++;
            results;
        end
    endtask : wb
    task automatic pace(input int x);
        int n, k;
        {n, k} = 0;
        while (k < 2 && n < 100) begin
            @(posedge clk_i);
            n++;
            if (tx_sym_ready_o[0] === 1'b1) begin
                if (k == 1) chk("spacing", x, n);
                {k, n} = {k + 1, 32'd0};
            end
        end
        if (k < 2) begin
            error_cnt++;
            results;
        end
    endtask : pace
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, ce_i, cyc_i, stb_i, we_i, adr_i, dat_i} = {2'b11, 45'h0};
        {sel_i, dbg_event_i, dbg_core_i, ext_rx_error_i} = 15'h7800;
        {ext_kind_i, proc_kind_i} = 32'he4e4_e4e4;
        ext_dest_i = 64'h7766_5544_3322_1100;
        proc_dest_i = ext_dest_i;
        {ext_junk_i, ext_dest_busy_i, ext_src_busy_i} = 24'haa_ccf0;
        {proc_junk_i, proc_dest_busy_i, proc_src_busy_i} = 24'haa_ccf0;
        {tx_sym_valid_i, tx_sym_last_i} = 16'h0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, IDX_EXT_SETUP, 0);
        chk("setup reset", 0, rd);
        for (int i = 0; i < 8; i++) begin
            e = {6'h0, i[1:0], ext_dest_i[i], 12'h0f3, 1'b0, i[0], i[1], i[2]};
            wb(1, IDX_EXT_STATUS + 8'(i), '1);
            wb(0, IDX_EXT_STATUS + 8'(i), 0);
            chk("ext status", e, rd);
            chk("direction", 4'hf, direction_o[i]);
            wb(1, IDX_PROC_STATUS + 8'(i), '1);
            wb(0, IDX_PROC_STATUS + 8'(i), 0);
            chk("proc status", e & 32'hffff_f0ff, rd);
            chk("nets", 4'hf, {network_o[i], proc_network_o[i]});
        end
        $display("test status done");
        wb(1, IDX_EXT_SETUP, 32'hc180_0000);
        chk("pulses", 2'b11, {hel[0], rxr[0]});
        chk("en wide", 2'b11, {link_enable_o[0], wide_mode_o[0]});
        repeat (8) @(posedge clk_i);
        ext_rx_error_i <= 8'h01;
        wb(0, IDX_EXT_SETUP, 0);
        chk("credit", 32'hce00_0000, rd);
        wb(1, IDX_EXT_SETUP, 32'h8000_1005);
        chk("gaps", 22'h1005, {sym_gap_o[0], tok_gap_o[0]});
        tx_sym_valid_i <= 8'h01;
        pace(4);
        tx_sym_last_i <= 8'h01;
        pace(7);
        tx_sym_valid_i <= 8'h00;
        $display("test link done");
        for (int k = 0; k < 8; k++) begin
            wb(1, IDX_FIXED_FWD + 8'(k), 32'h8000_0100 | k);
            chk("fwd", 32'h60 + k, {fwd_enable_o[let_t[k]], fwd_proc_o[let_t[k]],
                fwd_chanend_o[let_t[k]]});
        end
        for (int c = 1; c < 3; c++) begin
            {dbg_core_i, dbg_event_i} <= {2'(c), 1'b1};
            @(posedge clk_i);
            dbg_event_i <= 1'b0;
            wb(0, IDX_DEBUG_ORIGIN, 0);
            chk("debug origin", c, rd);
        end
        wb(1, IDX_SPARE_A, '1);
        wb(0, IDX_SPARE_A, 0);
        chk("spare", 3, rd);
        wb(1, 8'h28, '1);
        wb(0, 8'h28, 0);
        chk("unmapped", 0, rd);
        wb(1, IDX_SWITCH_CFG, 32'h8000_0000);
        wb(1, IDX_EXT_STATUS, 0);
        wb(0, IDX_EXT_STATUS, 0);
        chk("locked", 32'h0000_0f30, rd);
        $display("test misc done");
        results;
    end
endmodule : swlcs_link_setup_tb
